//--- rtl/vlcfg_unit.sv
// Summary of operation
// - config holds illegal, agnostic, width, multiplier fields
// - immediate forms use immediate, register form second source
// - register form restores full saved configuration
// - unsupported: illegal set, others cleared, length zero
// - requested illegal flag means unsupported
// - every configuration bit except the two agnostic flags is checked
// - nonzero source gives count; length to destination
// - zero source, nonzero destination: all-ones count
// - both zero: current length capped at maximum, no write
// - immediate count is five bits, zero-extended
// - maximum derived first, then granted length
// - count within maximum granted exactly
// - below twice maximum: between half and maximum
// - at least twice maximum grants maximum
// - grant is deterministic function of inputs
// - re-feeding read length reproduces it
`timescale 1ns/1ps
`include "vlcfg_defs.svh"
module vlcfg_unit (
	input  wire logic                  clock,           // core clock
	input  wire logic                  nrst,            // async reset, low
	input  wire logic                  reqValid,        // instruction issue strobe
	input  wire vlcfg_pkg::vlcfg_req_t req,             // operands and indices
	output logic [31:0]                configReg,       // configuration register
	output logic [31:0]                activeLengthReg, // active length
	output vlcfg_pkg::vlcfg_wb_t       wb               // register file write
);
	// ----------------------------------------
	// configuration source
	// ----------------------------------------
	wire logic [31:0] newCfg;
	wire logic        isReg;
	assign isReg  = (req.op == `VLCFG_OP_REGREG);
	assign newCfg = isReg ? req.cfgValue : {21'h000000, req.cfgImm};

	wire logic [2:0] sewField;
	wire logic [2:0] mulField;
	assign sewField = newCfg[`VLCFG_SEW_HI:`VLCFG_SEW_LO];
	assign mulField = newCfg[`VLCFG_MUL_HI:`VLCFG_MUL_LO];

	// ----------------------------------------
	// maximum length
	// ----------------------------------------
	// shift form: vlen/8 >> sew, then scaled by multiplier exponent
	wire logic [31:0] baseLen;
	wire logic [31:0] maxLen;
	wire logic        reqOk;
	assign baseLen = 32'(`VLCFG_VLEN / 8) >> sewField[1:0];
	assign maxLen  = mulField[2] ? (baseLen >> (3'h0 - mulField))
		: (baseLen << mulField[1:0]);
	// fractional multiplier must leave at least one element
	assign reqOk   = (maxLen != 32'h00000000);

	// ----------------------------------------
	// legality
	// ----------------------------------------
	// widths up to 64 supported; multiplier code 4 is reserved
	// bit 31 can only arrive through the register form
	wire logic illegal;
	assign illegal = newCfg[`VLCFG_ILL_BIT]
		|| (newCfg[`VLCFG_RSV_HI:`VLCFG_RSV_LO] != 23'h000000)
		|| sewField[2] || (mulField == 3'h4) || !reqOk;

	// ----------------------------------------
	// requested count
	// ----------------------------------------
	// the immediate-count form reuses the source field as the count itself
	wire logic        isImmCount;
	wire logic        srcZero;
	wire logic        dstZero;
	wire logic [31:0] reqCount;
	assign isImmCount = (req.op == `VLCFG_OP_IMMIMM);
	assign srcZero    = (req.srcIndex == 5'h00);
	assign dstZero    = (req.destIndex == 5'h00);
	assign reqCount   = isImmCount ? {27'h0000000, req.srcIndex}
		: !srcZero ? req.srcValue
		: !dstZero ? 32'hFFFFFFFF
		: activeLengthReg;

	// ----------------------------------------
	// grant: min(count, maximum) satisfies all length bounds
	// ----------------------------------------
	wire logic [31:0] grant;
	assign grant = (reqCount <= maxLen) ? reqCount : maxLen;

	wire logic        noWrite;
	assign noWrite = !isImmCount && srcZero && dstZero;

	// ----------------------------------------
	// state update
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			configReg       <= `VLCFG_CFG_RST;
			activeLengthReg <= `VLCFG_LEN_RST;
		end else if (reqValid) begin
			configReg       <= illegal ? `VLCFG_CFG_RST : {24'h000000, newCfg[7:0]};
			activeLengthReg <= illegal ? `VLCFG_LEN_RST : grant;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wb <= '0;
		end else begin
			wb.writeEn <= reqValid && !noWrite && !dstZero;
			wb.index   <= req.destIndex;
			wb.data    <= illegal ? `VLCFG_LEN_RST : grant;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_illegal_clears;
		@(posedge clock) disable iff (!nrst)
		reqValid && illegal |=> configReg == 32'h80000000 && activeLengthReg == 32'h0;
	endproperty
	a_illegal_clears: assert property (p_illegal_clears) else $error("illegal not cleared");

	property p_flag_in;
		@(posedge clock) disable iff (!nrst)
		reqValid && newCfg[31] |=> configReg[31];
	endproperty
	a_flag_in: assert property (p_flag_in) else $error("illegal input accepted");

	property p_reserved;
		@(posedge clock) disable iff (!nrst)
		reqValid && newCfg[30:8] != 23'h0 |=> configReg[31];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits ignored");

	property p_exact;
		@(posedge clock) disable iff (!nrst)
		reqValid && !illegal && reqCount <= maxLen |=> activeLengthReg == $past(reqCount);
	endproperty
	a_exact: assert property (p_exact) else $error("count not granted");

	property p_cap;
		@(posedge clock) disable iff (!nrst)
		reqValid && !illegal && reqCount >= (maxLen << 1) |=> activeLengthReg == $past(maxLen);
	endproperty
	a_cap: assert property (p_cap) else $error("maximum not granted");

	property p_imm;
		@(posedge clock) disable iff (!nrst)
		reqValid && !illegal && isImmCount && {27'h0000000, req.srcIndex} <= maxLen
			|=> activeLengthReg == {27'h0000000, $past(req.srcIndex)};
	endproperty
	a_imm: assert property (p_imm) else $error("immediate count wide");

	property p_keep;
		@(posedge clock) disable iff (!nrst)
		reqValid && noWrite |=> !wb.writeEn;
	endproperty
	a_keep: assert property (p_keep) else $error("zero form wrote register");

	property p_wb;
		@(posedge clock) disable iff (!nrst)
		reqValid && !dstZero && !srcZero |=> wb.writeEn && wb.data == activeLengthReg;
	endproperty
	a_wb: assert property (p_wb) else $error("destination not written");

	property p_allones;
		@(posedge clock) disable iff (!nrst)
		reqValid && !illegal && req.op != 2'h1 && srcZero && !dstZero
			|=> activeLengthReg == $past(maxLen);
	endproperty
	a_allones: assert property (p_allones) else $error("max not set");

	property p_imm_cfg;
		@(posedge clock) disable iff (!nrst)
		reqValid && !illegal && req.op != `VLCFG_OP_REGREG
			|=> configReg == {24'h000000, $past(req.cfgImm[7:0])};
	endproperty
	a_imm_cfg: assert property (p_imm_cfg) else $error("immediate config lost");

	property p_reg_cfg;
		@(posedge clock) disable iff (!nrst)
		reqValid && !illegal && req.op == `VLCFG_OP_REGREG
			|=> configReg == $past(req.cfgValue);
	endproperty
	a_reg_cfg: assert property (p_reg_cfg) else $error("register config lost");

	property p_ill_data;
		@(posedge clock) disable iff (!nrst)
		reqValid && illegal |=> wb.data == 32'h00000000;
	endproperty
	a_ill_data: assert property (p_ill_data) else $error("illegal length written");

	property p_bound;
		@(posedge clock) disable iff (!nrst)
		reqValid && !illegal
			|=> activeLengthReg <= $past(maxLen) && activeLengthReg <= $past(reqCount);
	endproperty
	a_bound: assert property (p_bound) else $error("grant above bound");

	property p_half;
		@(posedge clock) disable iff (!nrst)
		reqValid && !illegal && reqCount < (maxLen << 1)
			|=> {activeLengthReg, 1'b0} >= {1'b0, $past(reqCount)};
	endproperty
	a_half: assert property (p_half) else $error("grant below half count");

	property p_nonzero;
		@(posedge clock) disable iff (!nrst)
		reqValid && !illegal && reqCount != 32'h00000000 |=> activeLengthReg != 32'h00000000;
	endproperty
	a_nonzero: assert property (p_nonzero) else $error("nonzero count granted zero");

	property p_maxlen_int;
		@(posedge clock) disable iff (!nrst)
		reqValid && !illegal && !mulField[2]
			|-> (maxLen << sewField[1:0]) == (32'(`VLCFG_VLEN / 8) << mulField[1:0]);
	endproperty
	a_maxlen_int: assert property (p_maxlen_int) else $error("whole multiplier maximum");

	property p_maxlen_frac;
		@(posedge clock) disable iff (!nrst)
		reqValid && !illegal && mulField[2]
			|-> ((maxLen << sewField[1:0]) << (3'h0 - mulField)) == 32'(`VLCFG_VLEN / 8);
	endproperty
	a_maxlen_frac: assert property (p_maxlen_frac) else $error("fraction maximum");

	property p_wb_index;
		@(posedge clock) disable iff (!nrst)
		reqValid |=> wb.index == $past(req.destIndex);
	endproperty
	a_wb_index: assert property (p_wb_index) else $error("write index mismatch");
endmodule

//--- rtl/vlcfg_defs.svh
`ifndef VLCFG_DEFS_SVH
`define VLCFG_DEFS_SVH
// ----------------------------------------
// widths and field positions
// ----------------------------------------
`define VLCFG_XLEN        32
`define VLCFG_VLEN        128
`define VLCFG_ILL_BIT     31
`define VLCFG_MA_BIT      7
`define VLCFG_TA_BIT      6
`define VLCFG_SEW_HI      5
`define VLCFG_SEW_LO      3
`define VLCFG_MUL_HI      2
`define VLCFG_MUL_LO      0
`define VLCFG_RSV_HI      30
`define VLCFG_RSV_LO      8
// ----------------------------------------
// reset values
// ----------------------------------------
`define VLCFG_CFG_RST     32'h80000000
`define VLCFG_LEN_RST     32'h00000000
// ----------------------------------------
// operation codes
// ----------------------------------------
`define VLCFG_OP_REGIMM   2'h0
`define VLCFG_OP_IMMIMM   2'h1
`define VLCFG_OP_REGREG   2'h2
`endif

//--- rtl/vlcfg_pkg.sv
package vlcfg_pkg;
	typedef struct packed {
		logic [1:0]  op;         // instruction form
		logic [4:0]  destIndex;  // destination register index
		logic [4:0]  srcIndex;   // first source index or immediate count
		logic [31:0] srcValue;   // first source register contents
		logic [31:0] cfgValue;   // second source contents
		logic [10:0] cfgImm;     // immediate configuration field
	} vlcfg_req_t;

	typedef struct packed {
		logic        writeEn;    // destination write strobe
		logic [4:0]  index;      // destination index
		logic [31:0] data;       // granted length
	} vlcfg_wb_t;
endpackage

//--- tb/vlcfg_pipe_model.sv
`timescale 1ns/1ps
module vlcfg_pipe_model (
	input  wire logic                 clock,    // core clock
	input  wire vlcfg_pkg::vlcfg_wb_t wb,       // length write-back
	input  wire logic [4:0]           srcIdx,   // first source index
	input  wire logic [4:0]           cfgIdx,   // second source index
	output logic [31:0]               srcValue, // first source contents
	output logic [31:0]               cfgValue  // second source contents
);
	logic [31:0] regs [32];
	assign srcValue = regs[srcIdx];
	assign cfgValue = regs[cfgIdx];
	always @(posedge clock)
		if (wb.writeEn && wb.index != 5'h0) regs[wb.index] <= wb.data;
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic                  clock;
	logic                  nrst;
	logic                  reqValid;
	logic [31:0]           srcValue;
	logic [31:0]           cfgValue;
	logic [31:0]           configReg;
	logic [31:0]           activeLengthReg;
	logic [31:0]           expLen;
	vlcfg_pkg::vlcfg_req_t cmd;
	vlcfg_pkg::vlcfg_req_t req;
	vlcfg_pkg::vlcfg_wb_t  wb;
	int                    fails;
	int                    testsRun;
	assign req = {cmd.op, cmd.destIndex, cmd.srcIndex, srcValue, cfgValue, cmd.cfgImm};
	vlcfg_unit i_vlcfg_unit (.clock(clock), .nrst(nrst), .reqValid(reqValid), .req(req),
		.configReg(configReg), .activeLengthReg(activeLengthReg), .wb(wb));
	vlcfg_pipe_model i_vlcfg_pipe_model (.clock(clock), .wb(wb), .srcIdx(cmd.srcIndex),
		.cfgIdx(5'h1F), .srcValue(srcValue), .cfgValue(cfgValue));
	function automatic logic [31:0] maxLen(logic [31:0] c);
		int lg;
		lg = 4 - int'(c[5:3]) + int'(c[2:0]) - (c[2] ? 8 : 0);
		if (c[31] || c[30:8] != 0 || c[5] || c[2:0] == 3'h4 || lg < 0) return 32'h0;
		return 32'h1 << lg;
	endfunction
	task automatic check(logic [31:0] seen, logic [31:0] want);
		testsRun++;
		if (seen !== want) begin
			fails++;
			$display("ERROR %0t seen %h want %h", $time, seen, want);
		end
	endtask
	// two idle cycles first so the previous write-back has landed in the model
	task automatic issue(logic [1:0] op, logic [4:0] dst, logic [4:0] src, logic [31:0] cfg);
		logic [31:0] eff;
		logic [31:0] m;
		logic [31:0] cnt;
		repeat (2) @(posedge clock);
		i_vlcfg_pipe_model.regs[31] = cfg;
		cmd <= '{op, dst, src, 32'h0, 32'h0, cfg[10:0]};
		reqValid <= 1'b1;
		eff = (op == 2'h2) ? cfg : {21'h0, cfg[10:0]};
		m = maxLen(eff);
		cnt = (op == 2'h1) ? {27'h0, src} : (src != 5'h0) ? i_vlcfg_pipe_model.regs[src]
			: (dst != 5'h0) ? 32'hFFFFFFFF : expLen;
		expLen = (m == 32'h0) ? 32'h0 : (cnt < m) ? cnt : m;
		@(posedge clock);
		reqValid <= 1'b0;
		#1;
		check(configReg, (m == 32'h0) ? 32'h80000000 : eff);
		check(activeLengthReg, expLen);
		check(wb.data, expLen);
		check({26'h0, wb.writeEn, wb.index}, {26'h0, dst != 5'h0, dst});
	endtask
	task automatic testDone;
		$display("comparisons %0d mismatches %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		testDone;
	end
	initial begin
		logic [31:0] r;
		nrst = 1'b0;
		reqValid = 1'b0;
		cmd = '0;
		expLen = 32'h0;
		for (int i = 0; i < 32; i++) i_vlcfg_pipe_model.regs[i] = 32'(i * 9);
		void'($urandom(92));
		repeat (8) @(posedge clock);
		check(configReg, 32'h80000000);
		check(activeLengthReg, 32'h0);
		nrst <= 1'b1;
		$display("reset test done");
		for (int c = 0; c < 256; c++) issue(2'h2, 5'h3, 5'(c % 30 + 1), 32'(c));
		$display("sweep test done");
		issue(2'h2, 5'h3, 5'h2, 32'h80000008);
		issue(2'h2, 5'h3, 5'h2, 32'h00100008);
		issue(2'h0, 5'h3, 5'h2, 32'h00000108);
		issue(2'h1, 5'h4, 5'h1F, 32'h00000001);
		issue(2'h1, 5'h4, 5'h0, 32'h00000001);
		issue(2'h0, 5'h5, 5'h0, 32'h0000000D);
		issue(2'h0, 5'h0, 5'h0, 32'h0000000D);
		issue(2'h2, 5'h6, 5'h2, 32'h00000002);
		issue(2'h2, 5'h7, 5'h6, 32'h00000002);
		$display("corner test done");
		@(posedge clock);
		nrst <= 1'b0;
		@(posedge clock);
		#1;
		check(configReg, 32'h80000000);
		check(activeLengthReg, 32'h0);
		check({31'h0, wb.writeEn}, 32'h0);
		@(posedge clock);
		nrst <= 1'b1;
		expLen = 32'h0;
		$display("mid-run reset test done");
		for (int k = 0; k < 300; k++) begin
			r = $urandom;
			i_vlcfg_pipe_model.regs[r[11:7]] = $urandom_range(0, 300);
			issue(2'(r[1:0] % 3), 5'(r[6:2] | 5'(r[11:7] == 5'h0)), r[11:7],
				{r[31:30] == 2'h3, 21'h0, r[29:28] == 2'h3, 1'h0, r[19:12]});
		end
		$display("random test done");
		testDone;
	end
endmodule
